// *** pmta_table_access.sv ***
// table access path between core and 16-bit program memory
// assumes the core holds opValid until opDone; program memory answers with pmValid
// Functional notes
// - table read fetches one addressed program memory byte into the byte latch
// - table write copies the latch into a holding entry, never into flash
// - one 8-bit latch bridges 16-bit memory words and 8-bit data RAM
// - byte addressing with no alignment imposed on data tables
// - pointer is 22 bits; low 21 address memory, top selects config space
// - table read uses all 22 pointer bits to select the byte
// - table write selects the holding entry with only low 3, 4 or 5 bits
module pmta_table_access
	import pmta_pkg::*;
#(
	parameter int BLK_SEL_W = 5
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic opValid,
	input wire pmta_pkg::pmta_op_t opKind,
	input wire logic [7:0] loadData,
	input wire logic [21:0] tableBytePointer,
	output logic opDone,
	output logic [7:0] tableByteLatch,
	output logic pmReq,
	output logic [20:0] pmWordAddr,
	output logic pmCfgSpace,
	input wire logic [15:0] pmData,
	input wire logic pmValid,
	input wire logic [4:0] holdRdIdx,
	output logic [7:0] holdRdData
);
	import pmta_pkg::*;

	logic rstMeta_reg;
	logic rstSync_b;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_reg <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_b <= rstMeta_reg;
		end
	end

	pmta_hold_if hold ();
	pmta_hold_mem u_hold (
		.mclk(mclk),
		.rstSync_b(rstSync_b),
		.hold(hold.mem)
	);

	pmta_state_t state_reg, state_next;
	logic [7:0] latch_reg, latch_next;
	logic done_reg, done_next;
	logic req_reg, req_next;
	logic [20:0] addr_reg, addr_next;
	logic cfg_reg, cfg_next;
	logic oddByte_reg, oddByte_next;
	logic wrEn_next;
	logic [PMTA_BLK_SEL_W-1:0] wrIdx_next;
	logic [PMTA_BLK_SEL_W-1:0] selMask;
	logic opTake;
	logic fetchDone;

	// unused upper selector bits masked so smaller blocks alias low entries
	for (genvar b = 0; b < PMTA_BLK_SEL_W; b++) begin : g_selMask
		assign selMask[b] = (b < BLK_SEL_W);
	end

	// done gate keeps a level request from being taken twice
	assign opTake = (state_reg == PMTA_IDLE) && opValid && !done_reg;
	// pmValid counts only while a fetch is outstanding
	assign fetchDone = (state_reg == PMTA_FETCH) && pmValid;

	// fetch sequencer group
	always_comb begin
		state_next = state_reg;
		req_next = req_reg;
		addr_next = addr_reg;
		cfg_next = cfg_reg;
		oddByte_next = oddByte_reg;
		case (state_reg)
			PMTA_IDLE: begin
				if (opTake && opKind == PMTA_OP_READ) begin
					// word address is pointer bits 20..1, byte lane from bit 0
					addr_next = {1'b0, tableBytePointer[20:1]};
					cfg_next = tableBytePointer[PMTA_CFG_SPACE_BIT];
					oddByte_next = tableBytePointer[0];
					req_next = 1'b1;
					state_next = PMTA_FETCH;
				end
			end
			PMTA_FETCH: begin
				if (pmValid) begin
					req_next = 1'b0;
					state_next = PMTA_WAIT;
				end
			end
			PMTA_WAIT: begin
				// one idle cycle lets the core drop opValid after opDone
				state_next = PMTA_IDLE;
			end
			default: begin
				state_next = PMTA_IDLE;
				req_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			state_reg <= PMTA_IDLE;
			req_reg <= 1'b0;
			addr_reg <= '0;
			cfg_reg <= 1'b0;
			oddByte_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_reg <= req_next;
			addr_reg <= addr_next;
			cfg_reg <= cfg_next;
			oddByte_reg <= oddByte_next;
		end
	end

	// latch group
	always_comb begin
		latch_next = latch_reg;
		if (opTake && opKind == PMTA_OP_LOAD) begin
			latch_next = loadData;
		end else if (fetchDone) begin
			// exactly one byte of the word reaches the latch
			latch_next = oddByte_reg ? pmData[15:8] : pmData[7:0];
		end
	end

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			latch_reg <= PMTA_LATCH_RESET;
		end else begin
			latch_reg <= latch_next;
		end
	end

	// completion group: one pulse per taken request
	always_comb begin
		done_next = 1'b0;
		if (opTake && opKind != PMTA_OP_READ) begin
			done_next = 1'b1;
		end else if (fetchDone) begin
			done_next = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
		end
	end

	// holding write port; the memory registers it, so no flop here
	always_comb begin
		wrEn_next = 1'b0;
		wrIdx_next = '0;
		if (opTake && opKind == PMTA_OP_WRITE) begin
			// upper pointer bits play no part in entry selection
			wrEn_next = 1'b1;
			wrIdx_next = tableBytePointer[PMTA_BLK_SEL_W-1:0] & selMask;
		end
	end

	// write data is the latch itself, so a write never bypasses it
	assign hold.wrEn = wrEn_next;
	assign hold.wrIdx = wrIdx_next;
	assign hold.wrData = latch_reg;
	assign hold.rdIdx = holdRdIdx & selMask;

	assign opDone = done_reg;
	assign tableByteLatch = latch_reg;
	assign pmReq = req_reg;
	assign pmWordAddr = addr_reg;
	assign pmCfgSpace = cfg_reg;
	assign holdRdData = hold.rdData;
endmodule : pmta_table_access

// *** pmta_pkg.sv ***
// package for the program memory table access block
// assumes a single 50 MHz clock domain and one core issuing table operations
package pmta_pkg;
	localparam int PMTA_PTR_W = 22;
	localparam int PMTA_PM_ADDR_W = 21;
	localparam int PMTA_BYTE_W = 8;
	localparam int PMTA_WORD_W = 16;
	localparam int PMTA_BLK_SEL_W = 5;
	localparam int PMTA_BLK_ENTRIES = 1 << PMTA_BLK_SEL_W;
	localparam int PMTA_CFG_SPACE_BIT = 21;
	localparam logic [7:0] PMTA_LATCH_RESET = 8'h00;
	localparam logic [21:0] PMTA_PTR_RESET = 22'h000000;
	typedef enum logic [1:0] {PMTA_OP_NONE, PMTA_OP_READ, PMTA_OP_WRITE, PMTA_OP_LOAD} pmta_op_t;
	typedef enum {PMTA_IDLE, PMTA_FETCH, PMTA_WAIT} pmta_state_t;
endpackage : pmta_pkg

// *** pmta_hold_if.sv ***
// interface between the table access top and its holding register memory
// assumes both ends run on mclk
interface pmta_hold_if;
	import pmta_pkg::*;
	logic wrEn;
	logic [PMTA_BLK_SEL_W-1:0] wrIdx;
	logic [PMTA_BYTE_W-1:0] wrData;
	logic [PMTA_BLK_SEL_W-1:0] rdIdx;
	logic [PMTA_BYTE_W-1:0] rdData;
	modport ctrl (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
	modport mem (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface : pmta_hold_if

// *** pmta_hold_mem.sv ***
// write-block holding register memory, one byte per entry
// assumes reset already synchronised by the top; read data is registered
module pmta_hold_mem
	import pmta_pkg::*;
(
	input wire logic mclk,
	input wire logic rstSync_b,
	pmta_hold_if.mem hold
);
	logic [PMTA_BYTE_W-1:0] entry_reg [PMTA_BLK_ENTRIES];
	logic [PMTA_BYTE_W-1:0] rdData_reg;

	// erased flash reads as ones, so holding entries start there too
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			for (int i = 0; i < PMTA_BLK_ENTRIES; i++) begin
				entry_reg[i] <= 8'hFF;
			end
			rdData_reg <= 8'hFF;
		end else begin
			if (hold.wrEn) begin
				entry_reg[hold.wrIdx] <= hold.wrData;
			end
			rdData_reg <= entry_reg[hold.rdIdx];
		end
	end
	assign hold.rdData = rdData_reg;
endmodule : pmta_hold_mem

// *** pmta_table_access_asserts.sv ***
// port checks for the table access top
// assumes the core holds kind and pointer until opDone
module pmta_ta_asserts
	import pmta_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic opValid,
	input wire pmta_pkg::pmta_op_t opKind,
	input wire logic [7:0] loadData,
	input wire logic [21:0] tableBytePointer,
	input wire logic opDone,
	input wire logic [7:0] tableByteLatch,
	input wire logic pmReq,
	input wire logic [20:0] pmWordAddr,
	input wire logic pmCfgSpace,
	input wire logic [15:0] pmData,
	input wire logic pmValid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence rdTake; $rose(opValid) && opKind == PMTA_OP_READ; endsequence
	sequence served; pmReq && pmValid; endsequence
	rd_fetch_a: assert property (rdTake |=> pmReq && pmCfgSpace == $past(tableBytePointer[21])
		&& pmWordAddr == {1'b0, $past(tableBytePointer[20:1])}) else $error("bad fetch");
	req_hold_a: assert property (pmReq && !pmValid |=> pmReq) else $error("req dropped");
	rd_done_a: assert property (served |=> !pmReq && opDone) else $error("no read done");
	rd_byte_a: assert property (served |=> tableByteLatch == ($past(tableBytePointer[0]) ?
		$past(pmData[15:8]) : $past(pmData[7:0]))) else $error("bad byte");
	wr_done_a: assert property ($rose(opValid) && opKind != PMTA_OP_READ |=> opDone && !pmReq)
		else $error("no done");
	latch_load_a: assert property ($rose(opValid) && opKind == PMTA_OP_LOAD |=>
		tableByteLatch == $past(loadData)) else $error("bad load");
	latch_keep_a: assert property (!pmValid && !(opValid && opKind == PMTA_OP_LOAD) |=>
		$stable(tableByteLatch)) else $error("latch moved");
	done_pulse_a: assert property (opDone |=> !opDone) else $error("long done");
endmodule : pmta_ta_asserts
bind pmta_table_access pmta_ta_asserts chk (.mclk, .rst_b, .opValid, .opKind, .loadData, .tableBytePointer,
	.opDone, .tableByteLatch, .pmReq, .pmWordAddr, .pmCfgSpace, .pmData, .pmValid);

// *** pmta_pm_model.sv ***
// program memory stand-in, answers after 1 to 4 cycles
// assumes pmReq holds until pmValid
module pmta_pm_model (
	input wire logic mclk,
	input wire logic pmReq,
	input wire logic [20:0] pmWordAddr,
	input wire logic pmCfgSpace,
	output logic [15:0] pmData = 16'h0000,
	output logic pmValid = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] waitCnt = 2'h0;
	always @(posedge mclk) begin
		pmValid <= 1'b0;
		pmData <= ~pmData; // stale word must never pass for fresh data
		waitCnt <= 2'h0;
		if (pmReq && !pmValid) begin
			waitCnt <= waitCnt + 2'h1;
			if (waitCnt == pmWordAddr[1:0]) begin
				pmValid <= 1'b1;
				pmData <= {pmCfgSpace, pmWordAddr[6:0], pmWordAddr[7:0]};
			end
		end
	end
endmodule : pmta_pm_model

// *** test_pmta_table_access.sv ***
// self-checking bench for the table access top
// assumes the memory model answers within four cycles
module test_pmta_table_access;
	timeunit 1ns;
	timeprecision 1ns;
	import pmta_pkg::*;
	logic mclk = 1'b0, rst_b = 1'b0, opValid = 1'b0, opDone, pmReq, pmCfg, pmValid;
	pmta_op_t opKind = PMTA_OP_NONE;
	logic [7:0] loadData = 8'h00, latch, holdRd, expLatch = 8'h00;
	logic [7:0] holdMdl [16];
	logic [7:0] q [$];
	logic [21:0] ptr = 22'h000000;
	logic [20:0] pmAddr;
	logic [15:0] pmData;
	logic [4:0] holdIdx = 5'h00;
	logic [31:0] seed = 32'h00006F63;
	int err_total = 0;
	int n_compared = 0;
	always #10 mclk = ~mclk;
	pmta_table_access #(.BLK_SEL_W(4)) dut (.mclk, .rst_b, .opValid, .opKind, .loadData, .tableBytePointer(ptr),
		.opDone, .tableByteLatch(latch), .pmReq, .pmWordAddr(pmAddr), .pmCfgSpace(pmCfg), .pmData, .pmValid,
		.holdRdIdx(holdIdx), .holdRdData(holdRd));
	pmta_pm_model mem (.mclk, .pmReq, .pmWordAddr(pmAddr), .pmCfgSpace(pmCfg), .pmData, .pmValid);
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_hold(input logic [7:0] got, input logic [7:0] exp);
		chk(got, exp);
	endtask : chk_hold
	task automatic issue(input pmta_op_t k, input logic [21:0] p, input logic [7:0] d);
		opKind = k;
		ptr = p;
		loadData = d;
		opValid = 1'b1;
		if (k == PMTA_OP_READ) expLatch = p[0] ? {p[21], p[7:1]} : p[8:1];
		if (k == PMTA_OP_LOAD) expLatch = d;
		if (k == PMTA_OP_WRITE) holdMdl[p[3:0]] = expLatch;
		q.push_back(expLatch);
		for (int w = 0; w < 20 && opDone !== 1'b1; w++) @(negedge mclk);
		opValid = 1'b0;
		@(negedge mclk);
	endtask : issue
	task automatic tally_and_finish;
		if (err_total == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	always @(negedge mclk) if (opDone === 1'b1) chk(latch, q.pop_front());
	initial begin
		#100000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		foreach (holdMdl[i]) holdMdl[i] = 8'hFF;
		repeat (4) @(negedge mclk);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		for (int n = 0; n < 200; n++) begin
			seed = xs(seed);
			issue(pmta_op_t'(seed[1:0]), seed[31:10], seed[9:2]);
		end
		// an instruction word placed at an even pointer, low byte first
		issue(PMTA_OP_LOAD, 22'h000000, 8'h3C);
		issue(PMTA_OP_WRITE, 22'h000006, 8'h00);
		issue(PMTA_OP_LOAD, 22'h000000, 8'hA5);
		issue(PMTA_OP_WRITE, 22'h000007, 8'h00);
		for (int i = 0; i < 32; i++) begin
			holdIdx = 5'(i);
			@(negedge mclk);
			chk_hold(holdRd, holdMdl[i[3:0]]);
		end
		tally_and_finish();
	end
endmodule : test_pmta_table_access
